// *** verilog/citsr_pkg.sv ***
// constants shared by the current, input and temperature status bytes
// assumes a management link engine that decodes command codes for it
package citsr_pkg;

    // command codes seen on the management link
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_IOUT_STATUS = 8'h7b;
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
    localparam logic [7:0] CMD_TEMP_STATUS = 8'h7d;

    // field positions
    localparam int OC_FAULT_BIT = 7;
    localparam int OC_WARN_BIT = 5;
    localparam int IN_OVF_BIT = 7;
    localparam int IN_UVW_BIT = 5;
    localparam int IN_OFF_BIT = 3;
    localparam int OT_FAULT_BIT = 7;
    localparam int OT_WARN_BIT = 6;

    // writable latched positions per byte
    localparam logic [7:0] IOUT_LATCH_MASK = 8'ha0;
    localparam logic [7:0] INPUT_LATCH_MASK = 8'ha0;
    localparam logic [7:0] TEMP_LATCH_MASK = 8'hc0;

    // values after reset
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] READ_DATA_RST = 8'h00;
    localparam logic INPUT_OFF_RST = 1'b1;
    localparam logic [23:0] ALERT_MASK_NONE = 24'h000000;

    // link side request state
    typedef enum logic [0:0] {
        LK_IDLE = 1'b0,
        LK_WAIT = 1'b1
    } citsr_lk_state_t;

endpackage

// *** verilog/citsr_sync.sv ***
// two flip-flop level synchroniser, any width
// assumes the input is quasi-static relative to the destination clock
`timescale 1ns/1ps
module citsr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// *** verilog/citsr_pulse_sync.sv ***
// toggle to pulse crossing: one destination pulse per source toggle
// assumes toggles are spaced by a full handshake round trip
`timescale 1ns/1ps
module citsr_pulse_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tog_i,
    output logic pulse_o
);
    logic meta;
    logic tog_s;
    logic tog_d;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            tog_s <= 1'b0;
            tog_d <= 1'b0;
            pulse_o <= 1'b0;
        end else begin
            meta <= tog_i;
            tog_s <= meta;
            tog_d <= tog_s;
            pulse_o <= tog_s ^ tog_d;
        end
    end
endmodule

// *** verilog/citsr_regs.sv ***
// current, input supply and die temperature status bytes
// assumes a link engine on link_clk_i handing over decoded byte commands
// and fault detectors driving level inputs from any clock
//
// Overview of operation
// - three status bytes read and written whole at codes 7Bh, 7Ch, 7Dh
// - current byte bit 7 latches on overcurrent fault until cleared
// - current byte bit 5 latches on overcurrent warning until cleared
// - unsupported bits of all three bytes read zero and ignore writes
// - flags clear on clear-all command or writing one; zero leaves them
// - input byte bit 7 latches on input overvoltage fault
// - input byte bit 5 latches on input undervoltage warning
// - input byte bit 3 live: one while input off, zero while on
// - live bit set when input below turn-on or bias low; no alert
// - live bit reads one straight after reset, with no alert
// - undervoltage warning flag can raise the alert output
// - undervoltage warning ignored until input first passes turn-on
// - each alerting bit has a mask bit; only unmasked flags alert
// - temperature byte bit 7 latches on overtemperature fault
// - temperature byte bit 6 latches on overtemperature warning
// - summary bit per byte is the or of its flags
// - status word bit 14 copy is one while a current flag is set
`timescale 1ns/1ps
module citsr_regs
    import citsr_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic [7:0] lk_cmd_i,
    input wire logic [7:0] lk_wdata_i,
    input wire logic lk_wr_i,
    input wire logic lk_rd_i,
    output logic [7:0] lk_rdata_o,
    output logic lk_ack_o,
    output logic lk_busy_o,
    input wire logic oc_fault_i,
    input wire logic oc_warn_i,
    input wire logic vin_ov_fault_i,
    input wire logic vin_uv_warn_i,
    input wire logic vin_above_on_i,
    input wire logic bias_low_i,
    input wire logic ot_fault_i,
    input wire logic ot_warn_i,
    input wire logic [23:0] alert_mask_i,
    output logic alert_o,
    output logic iout_summary_o,
    output logic input_summary_o,
    output logic temp_summary_o,
    output logic word_iout_bit_o
);
    function automatic logic [7:0] latch_next(input logic [7:0] cur,
                                              input logic [7:0] set,
                                              input logic [7:0] clr,
                                              input logic clr_all);
        logic [7:0] kill;
        kill = clr_all ? 8'hff : clr;
        latch_next = (cur & ~kill) | set;
    endfunction

    function automatic logic alert_calc(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic [7:0] c,
                                        input logic [23:0] m);
        alert_calc = |(a & IOUT_LATCH_MASK & ~m[23:16])
                   | |(b & INPUT_LATCH_MASK & ~m[15:8])
                   | |(c & TEMP_LATCH_MASK & ~m[7:0]);
    endfunction

    // reset release in both domains
    logic [1:0] rst_pipe, lk_rst_pipe;
    logic rst_n, lk_rst_n;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lk_rst_pipe <= 2'b00;
        end else begin
            lk_rst_pipe <= {lk_rst_pipe[0], 1'b1};
        end
    end
    assign lk_rst_n = lk_rst_pipe[1];

    // link side: capture one request, wait for the answer
    citsr_lk_state_t lk_state;
    logic [7:0] lk_cmd, lk_data, rd_hold;
    logic lk_op_wr, req_tog, ack_tog, ack_pulse, req_pulse;

    always_ff @(posedge link_clk_i or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
            lk_state <= LK_IDLE;
            lk_cmd <= STATUS_RST;
            lk_data <= STATUS_RST;
            lk_op_wr <= 1'b0;
            req_tog <= 1'b0;
            lk_busy_o <= 1'b0;
            lk_ack_o <= 1'b0;
            lk_rdata_o <= READ_DATA_RST;
        end else begin
            lk_ack_o <= 1'b0;
            case (lk_state)
                LK_IDLE: begin
                    if (lk_wr_i || lk_rd_i) begin
                        lk_cmd <= lk_cmd_i;
                        lk_data <= lk_wdata_i;
                        lk_op_wr <= lk_wr_i;
                        req_tog <= ~req_tog;
                        lk_busy_o <= 1'b1;
                        lk_state <= LK_WAIT;
                    end
                end
                LK_WAIT: begin
                    if (ack_pulse) begin
                        lk_rdata_o <= rd_hold;
                        lk_ack_o <= 1'b1;
                        lk_busy_o <= 1'b0;
                        lk_state <= LK_IDLE;
                    end
                end
                default: begin
                    lk_state <= LK_IDLE;
                end
            endcase
        end
    end

    citsr_pulse_sync u_req_sync (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .tog_i(req_tog),
        .pulse_o(req_pulse)
    );

    citsr_pulse_sync u_ack_sync (
        .clk_i(link_clk_i),
        .rst_n_i(lk_rst_n),
        .tog_i(ack_tog),
        .pulse_o(ack_pulse)
    );

    // detector inputs brought onto the system clock
    logic [7:0] det_s;
    logic oc_fault_s, oc_warn_s, vin_ov_s, vin_uv_s;
    logic vin_above_s, bias_low_s, ot_fault_s, ot_warn_s;

    citsr_sync #(
        .W(8),
        .RST_VAL(8'h00)
    ) u_det_sync (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .d_i({oc_fault_i, oc_warn_i, vin_ov_fault_i, vin_uv_warn_i,
              vin_above_on_i, bias_low_i, ot_fault_i, ot_warn_i}),
        .q_o(det_s)
    );
    assign {oc_fault_s, oc_warn_s, vin_ov_s, vin_uv_s,
            vin_above_s, bias_low_s, ot_fault_s, ot_warn_s} = det_s;

    // command decode on the system clock; link regs are stable here
    logic wr_req, clr_all;
    logic [7:0] clr_iout, clr_input, clr_temp;

    assign wr_req = req_pulse && lk_op_wr;
    assign clr_all = wr_req && (lk_cmd == CMD_CLEAR_FAULTS);
    assign clr_iout = (wr_req && lk_cmd == CMD_IOUT_STATUS) ?
                      (lk_data & IOUT_LATCH_MASK) : 8'h00;
    assign clr_input = (wr_req && lk_cmd == CMD_INPUT_STATUS) ?
                       (lk_data & INPUT_LATCH_MASK) : 8'h00;
    assign clr_temp = (wr_req && lk_cmd == CMD_TEMP_STATUS) ?
                      (lk_data & TEMP_LATCH_MASK) : 8'h00;

    // latched flags
    logic [7:0] iout_flags, input_flags, temp_flags;
    logic uv_armed, in_off;
    logic [7:0] set_iout, set_input, set_temp;
    logic [7:0] next_iout, next_input, next_temp;

    always_comb begin
        set_iout = 8'h00;
        set_iout[OC_FAULT_BIT] = oc_fault_s;
        set_iout[OC_WARN_BIT] = oc_warn_s;
        set_input = 8'h00;
        set_input[IN_OVF_BIT] = vin_ov_s;
        set_input[IN_UVW_BIT] = vin_uv_s && uv_armed;
        set_temp = 8'h00;
        set_temp[OT_FAULT_BIT] = ot_fault_s;
        set_temp[OT_WARN_BIT] = ot_warn_s;
    end

    assign next_iout = latch_next(iout_flags, set_iout, clr_iout,
                                  clr_all);
    assign next_input = latch_next(input_flags, set_input, clr_input,
                                   clr_all);
    assign next_temp = latch_next(temp_flags, set_temp, clr_temp,
                                  clr_all);

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            iout_flags <= STATUS_RST;
            input_flags <= STATUS_RST;
            temp_flags <= STATUS_RST;
        end else begin
            iout_flags <= next_iout;
            input_flags <= next_input;
            temp_flags <= next_temp;
        end
    end

    // warning arms once the input first passes turn-on
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            uv_armed <= 1'b0;
        end else if (vin_above_s) begin
            uv_armed <= 1'b1;
        end
    end

    // live input-off bit, never latched
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_off <= INPUT_OFF_RST;
        end else begin
            in_off <= !vin_above_s || bias_low_s;
        end
    end

    // read answer and acknowledge toggle
    logic [7:0] rd_value;

    always_comb begin
        case (lk_cmd)
            CMD_IOUT_STATUS: rd_value = iout_flags;
            CMD_INPUT_STATUS: begin
                rd_value = input_flags;
                rd_value[IN_OFF_BIT] = in_off;
            end
            CMD_TEMP_STATUS: rd_value = temp_flags;
            default: rd_value = READ_DATA_RST;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_hold <= READ_DATA_RST;
            ack_tog <= 1'b0;
        end else if (req_pulse) begin
            if (!lk_op_wr) begin
                rd_hold <= rd_value;
            end
            ack_tog <= ~ack_tog;
        end
    end

    // alert and summaries, from the flags as they will stand
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            alert_o <= 1'b0;
            iout_summary_o <= 1'b0;
            input_summary_o <= 1'b0;
            temp_summary_o <= 1'b0;
            word_iout_bit_o <= 1'b0;
        end else begin
            alert_o <= alert_calc(next_iout, next_input, next_temp,
                                  alert_mask_i);
            iout_summary_o <= |next_iout;
            input_summary_o <= |next_input;
            temp_summary_o <= |next_temp;
            word_iout_bit_o <= |next_iout;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_read_iout;
        req_pulse && !lk_op_wr && lk_cmd == CMD_IOUT_STATUS;
    endsequence

    chk_read_iout_data: assert property (
        s_read_iout |=> rd_hold == $past(iout_flags))
        else $error("current status read data wrong");

    chk_ocf_latch_set: assert property (
        oc_fault_s |=> iout_flags[OC_FAULT_BIT])
        else $error("overcurrent fault not latched");

    chk_ocw_latch_set: assert property (
        oc_warn_s |=> iout_flags[OC_WARN_BIT])
        else $error("overcurrent warning not latched");

    chk_unsup_bits_zero: assert property (
        (iout_flags & ~IOUT_LATCH_MASK) == 8'h00 &&
        (input_flags & ~INPUT_LATCH_MASK) == 8'h00 &&
        (temp_flags & ~TEMP_LATCH_MASK) == 8'h00)
        else $error("unsupported status bit set");

    chk_flag_hold_clear: assert property (
        iout_flags[OC_FAULT_BIT] && !clr_all &&
        !clr_iout[OC_FAULT_BIT] |=> iout_flags[OC_FAULT_BIT])
        else $error("overcurrent fault flag lost");

    chk_write_one_clear: assert property (
        clr_temp[OT_FAULT_BIT] && !ot_fault_s
        |=> !temp_flags[OT_FAULT_BIT])
        else $error("write one did not clear flag");

    chk_clear_all_flags: assert property (
        clr_all && !oc_warn_s |=> !iout_flags[OC_WARN_BIT])
        else $error("clear all missed warning flag");

    chk_ovf_latch_set: assert property (
        vin_ov_s |=> input_flags[IN_OVF_BIT])
        else $error("input overvoltage not latched");

    chk_uvw_latch_set: assert property (
        vin_uv_s && uv_armed |=> input_flags[IN_UVW_BIT])
        else $error("input undervoltage warning not latched");

    chk_live_off_bit: assert property (
        ##1 in_off == ($past(!vin_above_s) || $past(bias_low_s)))
        else $error("live input off bit wrong");

    chk_uvw_before_arm: assert property (
        !uv_armed |-> !input_flags[IN_UVW_BIT])
        else $error("undervoltage warning before arming");

    chk_alert_mask_gate: assert property (
        ##1 alert_o == alert_calc(iout_flags, input_flags, temp_flags,
                                  $past(alert_mask_i)))
        else $error("alert does not follow masked flags");

    chk_live_no_alert: assert property (
        iout_flags == 8'h00 && input_flags == 8'h00 &&
        temp_flags == 8'h00 |-> !alert_o)
        else $error("alert raised with no latched flag");

    chk_otf_latch_set: assert property (
        ot_fault_s |=> temp_flags[OT_FAULT_BIT])
        else $error("overtemperature fault not latched");

    chk_otw_latch_set: assert property (
        ot_warn_s |=> temp_flags[OT_WARN_BIT])
        else $error("overtemperature warning not latched");

    chk_summary_or: assert property (
        iout_summary_o == |iout_flags &&
        input_summary_o == |input_flags &&
        temp_summary_o == |temp_flags)
        else $error("summary bit differs from flags");

    chk_word_iout_bit: assert property (
        word_iout_bit_o == |iout_flags)
        else $error("status word current bit wrong");

endmodule

// *** testbench/citsr_host.sv ***
// host model on the management link side of the status bytes
// assumes the link engine contract: one-cycle request pulse, ack later
`timescale 1ns/1ps
module citsr_host (
    input wire logic link_clk_i,
    input wire logic [7:0] lk_rdata_i,
    input wire logic lk_ack_i,
    input wire logic lk_busy_i,
    output logic [7:0] lk_cmd_o,
    output logic [7:0] lk_wdata_o,
    output logic lk_wr_o,
    output logic lk_rd_o
);
    initial begin
        lk_cmd_o = 8'h5a;
        lk_wdata_o = 8'ha5;
        lk_wr_o = 1'b0;
        lk_rd_o = 1'b0;
    end

    // one byte read or write; gap idle cycles make the host slow
    task automatic xfer(input logic wr, input logic [7:0] cmd,
                        input logic [7:0] wd, input int gap,
                        output logic [7:0] rd, output logic ok);
        logic seen_busy;
        ok = 1'b0;
        rd = 8'h00;
        seen_busy = 1'b0;
        repeat (gap) @(posedge link_clk_i);
        @(posedge link_clk_i);
        #1;
        lk_cmd_o = cmd;
        lk_wdata_o = wd;
        lk_wr_o = wr;
        lk_rd_o = !wr;
        @(posedge link_clk_i);
        #1;
        lk_wr_o = 1'b0;
        lk_rd_o = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge link_clk_i);
            // busy must stand while waiting and drop with the answer
            if (lk_busy_i === 1'b1) begin
                seen_busy = 1'b1;
            end
            if (lk_ack_i === 1'b1) begin
                rd = lk_rdata_i;
                ok = seen_busy && (lk_busy_i === 1'b0);
            end
        end
        #1;
        // released lines no longer show the old byte
        lk_cmd_o = ~lk_cmd_o;
        lk_wdata_o = ~lk_wdata_o;
    endtask
endmodule

// *** testbench/current_input_temp_status_regs_test.sv ***
// self-checking bench for the three status bytes
// assumes citsr_regs with the host model on its link side
`timescale 1ns/1ps
module current_input_temp_status_regs_test;
    import citsr_pkg::*;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] det = 6'h00;
    logic above_on = 1'b0;
    logic bias_low = 1'b0;
    logic [23:0] mask = 24'h000000;
    logic [7:0] cmd, wdata, rdata;
    logic wr, rd, ack, busy, alert, s_iout, s_in, s_temp, w14;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    int exp_q[3] = '{0, 0, 0};
    int bitpos[6] = '{7, 5, 7, 5, 7, 6};
    logic [7:0] latch[3] = '{8'ha0, 8'ha0, 8'hc0};
    bit live = 1'b1;
    bit armed = 1'b0;
    logic [31:0] seed = 32'd98416;

    always #50 ref_clk = ~ref_clk;
    initial begin
        #13;
        forever #40 link_clk = ~link_clk;
    end

    citsr_regs dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .link_clk_i(link_clk), .lk_cmd_i(cmd), .lk_wdata_i(wdata),
        .lk_wr_i(wr), .lk_rd_i(rd), .lk_rdata_o(rdata), .lk_ack_o(ack),
        .lk_busy_o(busy), .oc_fault_i(det[0]), .oc_warn_i(det[1]),
        .vin_ov_fault_i(det[2]), .vin_uv_warn_i(det[3]),
        .vin_above_on_i(above_on), .bias_low_i(bias_low),
        .ot_fault_i(det[4]), .ot_warn_i(det[5]), .alert_mask_i(mask),
        .alert_o(alert), .iout_summary_o(s_iout),
        .input_summary_o(s_in), .temp_summary_o(s_temp),
        .word_iout_bit_o(w14));

    citsr_host host (.link_clk_i(link_clk), .lk_rdata_i(rdata),
        .lk_ack_i(ack), .lk_busy_i(busy), .lk_cmd_o(cmd),
        .lk_wdata_o(wdata), .lk_wr_o(wr), .lk_rd_o(rd));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
        n_compared++;
        if (got !== want) begin
            n_fail++;
            $display("[ERR] %0t byte got %h want %h", $time, got, want);
        end
    endtask

    task automatic cmp1(input logic got, input logic want);
        n_compared++;
        if (got !== want) begin
            n_fail++;
            $display("[ERR] %0t bit got %b want %b", $time, got, want);
        end
    endtask

    task automatic ref_wait(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic access(input logic w, input logic [7:0] c,
                          input logic [7:0] d, output logic [7:0] q);
        logic ok;
        host.xfer(w, c, d, int'(rnd() % 3), q, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t bad answer to %h", $time, c);
        end
    endtask

    // raise detector levels briefly and record the expected latches
    task automatic pulse(input logic [5:0] m);
        ref_wait(1);
        det = m;
        ref_wait(4);
        det = 6'h00;
        ref_wait(8);
        for (int i = 0; i < 6; i++)
            if (m[i] && (i != 3 || armed))
                exp_q[i / 2] |= 1 << bitpos[i];
    endtask

    task automatic write_clr(input int k, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, CMD_IOUT_STATUS + 8'(k), d, q);
        exp_q[k] &= ~int'(d & latch[k]);
    endtask

    task automatic check_all();
        logic [7:0] q;
        logic [7:0] a;
        for (int k = 0; k < 3; k++) begin
            access(1'b0, CMD_IOUT_STATUS + 8'(k), 8'h00, q);
            cmp8(q, 8'(exp_q[k]) | ((k == 1 && live) ? 8'h08 : 8'h00));
        end
        a = (8'(exp_q[0]) & ~mask[23:16]) | (8'(exp_q[1]) & ~mask[15:8])
            | (8'(exp_q[2]) & ~mask[7:0]);
        cmp1(alert, |a);
        cmp1(s_iout, exp_q[0] != 0);
        cmp1(s_in, exp_q[1] != 0);
        cmp1(s_temp, exp_q[2] != 0);
        cmp1(w14, exp_q[0] != 0);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            $display("[ERR] %0t run did not finish", $time);
            conclude();
        end
    end

    initial begin
        logic [7:0] q;
        logic [31:0] r;
        int i;
        repeat (16) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        ref_wait(6);
        check_all();
        pulse(6'h08);
        check_all();
        ref_wait(1);
        above_on = 1'b1;
        ref_wait(8);
        live = 1'b0;
        armed = 1'b1;
        check_all();
        ref_wait(1);
        bias_low = 1'b1;
        ref_wait(8);
        live = 1'b1;
        check_all();
        ref_wait(1);
        bias_low = 1'b0;
        ref_wait(8);
        live = 1'b0;
        repeat (14) begin
            r = rnd();
            i = int'(r % 6);
            ref_wait(1);
            mask = r[31:8];
            pulse(6'h01 << i);
            check_all();
            write_clr(i / 2, r[7:0]);
            check_all();
        end
        pulse(6'h3f);
        mask = 24'hffffff;
        check_all();
        ref_wait(1);
        mask = 24'h000000;
        check_all();
        ref_wait(1);
        det = 6'h01;
        ref_wait(6);
        write_clr(0, 8'hff);
        exp_q[0] |= 8'h80;
        ref_wait(1);
        det = 6'h00;
        ref_wait(8);
        check_all();
        access(1'b1, CMD_CLEAR_FAULTS, 8'h00, q);
        exp_q = '{0, 0, 0};
        check_all();
        access(1'b1, 8'h7e, 8'hff, q);
        access(1'b0, 8'h7a, 8'h00, q);
        cmp8(q, 8'h00);
        check_all();
        conclude();
    end
endmodule
